// ### hw/icg_info_cmd.sv
// Local design decisions: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "icg_consts.svh"
module icg_info_cmd import icg_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [31:0] wbDatW,
  input wire logic [3:0] wbSel,
  output logic [31:0] wbDatR,
  output logic wbAck,
  // device state events
  input wire logic authDone,
  input wire logic [3:0] authSlot,
  input wire logic authClear,
  input wire logic volatileSeedEvent,
  input wire logic nonvolatileSeedEvent,
  // gpio pin
  input wire logic gpioIn,
  output logic gpioOut,
  output logic gpioOe
);
  logic wrStrobe;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrSel;
  logic [31:0] readMux;

  // bus slave: registered ack one cycle after the request
  icg_wb_slave uBus (
    .clk(clk),
    .rst_b(rst_b),
    .wbCyc(wbCyc),
    .wbStb(wbStb),
    .wbWe(wbWe),
    .wbAdr(wbAdr),
    .wbDatW(wbDatW),
    .wbSel(wbSel),
    .wbDatR(wbDatR),
    .wbAck(wbAck),
    .readMux(readMux),
    .wrStrobe(wrStrobe),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrSel(wrSel)
  );

  // configuration: addr cfg byte, pin function, interface select, signal key slot
  logic [7:0] addrCfg_r;
  logic [7:0] addrCfg_nxt;
  logic [1:0] pinFnRaw_r;
  logic [1:0] pinFnRaw_nxt;
  logic singleWire_r;
  logic singleWire_nxt;
  logic [3:0] signalKeySlot_r;
  logic [3:0] signalKeySlot_nxt;
  icg_pin_fn_t pinFn;
  assign pinFn = icg_pin_fn_t'(pinFnRaw_r);

  // decoded register writes; a command needs all four byte lanes
  logic cfgWrite;
  logic cmdWrite;
  assign cfgWrite = wrStrobe && (wrAddr == `ICG_ADDR_CFG);
  assign cmdWrite = wrStrobe && (wrAddr == `ICG_ADDR_CMD) && (wrSel == 4'hf);

  always_comb begin
    addrCfg_nxt = addrCfg_r;
    pinFnRaw_nxt = pinFnRaw_r;
    singleWire_nxt = singleWire_r;
    signalKeySlot_nxt = signalKeySlot_r;
    if (cfgWrite) begin
      if (wrSel[0]) begin
        addrCfg_nxt = wrData[7:0];
      end
      if (wrSel[1]) begin
        pinFnRaw_nxt = wrData[9:8];
        singleWire_nxt = wrData[12];
      end
      if (wrSel[2]) begin
        signalKeySlot_nxt = wrData[19:16];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      addrCfg_r <= 8'h00;
      pinFnRaw_r <= 2'h0;
      singleWire_r <= 1'b1;
      signalKeySlot_r <= 4'h0;
    end else begin
      addrCfg_r <= addrCfg_nxt;
      pinFnRaw_r <= pinFnRaw_nxt;
      singleWire_r <= singleWire_nxt;
      signalKeySlot_r <= signalKeySlot_nxt;
    end
  end

  // dynamic state flags; hardware set wins over clear
  logic authorization_valid_flag_r;
  logic authorization_valid_flag_nxt;
  logic [3:0] authSlot_r;
  logic [3:0] authSlot_nxt;
  logic volSeed_r;
  logic volSeed_nxt;
  logic nvSeed_r;
  logic nvSeed_nxt;

  always_comb begin
    authorization_valid_flag_nxt = authorization_valid_flag_r;
    authSlot_nxt = authSlot_r;
    volSeed_nxt = volSeed_r | volatileSeedEvent;
    nvSeed_nxt = nvSeed_r | nonvolatileSeedEvent;
    if (authClear) begin
      authorization_valid_flag_nxt = 1'b0;
    end
    if (authDone) begin
      authorization_valid_flag_nxt = 1'b1;
      authSlot_nxt = authSlot;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      authorization_valid_flag_r <= 1'b0;
      authSlot_r <= 4'h0;
      volSeed_r <= 1'b0;
      nvSeed_r <= 1'b0;
    end else begin
      authorization_valid_flag_r <= authorization_valid_flag_nxt;
      authSlot_r <= authSlot_nxt;
      volSeed_r <= volSeed_nxt;
      nvSeed_r <= nvSeed_nxt;
    end
  end

  // command engine
  icg_state_t st_r;
  icg_state_t st_nxt;
  logic [31:0] cmd_r;
  logic [31:0] cmd_nxt;
  logic [31:0] resp_r;
  logic [31:0] resp_nxt;
  logic [7:0] errCode_r;
  logic [7:0] errCode_nxt;
  logic busy_r;
  logic busy_nxt;
  logic done_r;
  logic done_nxt;
  logic [7:0] execCode;
  logic [31:0] execResp;
  logic execPin;

  // pin controller interface
  logic pinGo;
  logic pinErr;
  logic [7:0] pinState;
  logic pinOutW;
  logic pinOeW;
  logic latchW;
  logic [7:0] opcode;
  logic [7:0] mode;
  logic [15:0] secondParameter;
  logic authMatch;
  logic [7:0] stateByte1;

  // command word fields
  assign opcode = cmd_r[`ICG_CMD_OP_MSB:`ICG_CMD_OP_LSB];
  assign mode = cmd_r[`ICG_CMD_MODE_MSB:`ICG_CMD_MODE_LSB];
  assign secondParameter = cmd_r[15:0];
  // authorization pin function: latch writes and non-default drive need a valid authorization on the signal key slot
  assign authMatch = authorization_valid_flag_r && (authSlot_r == signalKeySlot_r);

  // state-reporting byte
  always_comb begin
    stateByte1 = 8'h00;
    stateByte1[6:3] = authSlot_r;
    stateByte1[2] = authorization_valid_flag_r;
    stateByte1[1] = volSeed_r;
    stateByte1[0] = nvSeed_r;
  end

  // result of the latched command, applied in the exec state
  always_comb begin
    execCode = 8'h00;
    execResp = 32'h0;
    execPin = 1'b0;
    if (opcode != `ICG_OPCODE_INFO) begin
      execCode = `ICG_ERR_PARSE;
    end else begin
      case (mode)
        `ICG_MODE_STATE: begin
          execResp = {8'h00, stateByte1, 8'h00, 8'h00};
        end
        `ICG_MODE_PIN: begin
          execPin = 1'b1;
          if (pinErr) begin
            execCode = `ICG_ERR_EXEC;
          end else begin
            execResp = {pinState, 24'h0};
          end
        end
        default: begin
          execCode = `ICG_ERR_PARSE;
        end
      endcase
    end
  end

  // idle takes a command, exec latches its result, done flags completion
  always_comb begin
    st_nxt = st_r;
    cmd_nxt = cmd_r;
    resp_nxt = resp_r;
    errCode_nxt = errCode_r;
    busy_nxt = busy_r;
    done_nxt = done_r;
    pinGo = 1'b0;
    case (st_r)
      ICG_IDLE: begin
        if (cmdWrite) begin
          cmd_nxt = wrData;
          busy_nxt = 1'b1;
          done_nxt = 1'b0;
          st_nxt = ICG_EXEC;
        end
      end
      ICG_EXEC: begin
        st_nxt = ICG_DONE;
        errCode_nxt = execCode;
        resp_nxt = execResp;
        pinGo = execPin & ~pinErr;
      end
      ICG_DONE: begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        st_nxt = ICG_IDLE;
      end
      default: st_nxt = ICG_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= ICG_IDLE;
      cmd_r <= 32'h0;
      resp_r <= 32'h0;
      errCode_r <= 8'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cmd_r <= cmd_nxt;
      resp_r <= resp_nxt;
      errCode_r <= errCode_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  // pin controller: drive, direction and intrusion latch
  icg_pin_ctrl uPin (
    .clk(clk),
    .rst_b(rst_b),
    .go(pinGo),
    .secondParameter(secondParameter),
    .addrCfg(addrCfg_r),
    .pinFn(pinFn),
    .singleWire(singleWire_r),
    .authMatch(authMatch),
    .gpioIn(gpioIn),
    .err(pinErr),
    .stateByte(pinState),
    .pinOut(pinOutW),
    .pinOe(pinOeW),
    .intrusionLatch(latchW)
  );

  // pin drive comes straight from the controller flops
  assign gpioOut = pinOutW;
  assign gpioOe = pinOeW;

  // readback words; unmapped offsets read zero
  logic [31:0] cfgWord;
  logic [31:0] statWord;
  logic [31:0] pinWord;
  logic [31:0] stateWord;
  assign cfgWord = {12'h0, signalKeySlot_r, 3'h0, singleWire_r, 2'h0, pinFnRaw_r, addrCfg_r};
  assign statWord = {16'h0, errCode_r, 6'h0, done_r, busy_r};
  assign pinWord = {29'h0, latchW, pinOeW, pinOutW};
  assign stateWord = {24'h0, stateByte1};

  always_comb begin
    readMux = 32'h0;
    case (wbAdr)
      `ICG_ADDR_CMD: begin
        readMux = cmd_r;
      end
      `ICG_ADDR_CFG: begin
        readMux = cfgWord;
      end
      `ICG_ADDR_STATE: begin
        readMux = stateWord;
      end
      `ICG_ADDR_RESP: begin
        readMux = resp_r;
      end
      `ICG_ADDR_STAT: begin
        readMux = statWord;
      end
      `ICG_ADDR_PIN: begin
        readMux = pinWord;
      end
      default: begin
        readMux = 32'h0;
      end
    endcase
  end
endmodule : icg_info_cmd

// ### hw/icg_pin_ctrl.sv
`timescale 1ns/1ps
`include "icg_consts.svh"
module icg_pin_ctrl import icg_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // request
  input wire logic go,
  input wire logic [15:0] secondParameter,
  input wire logic [7:0] addrCfg,
  input wire icg_pin_fn_t pinFn,
  input wire logic singleWire,
  input wire logic authMatch,
  // pin
  input wire logic gpioIn,
  // result
  output logic err,
  output logic [7:0] stateByte,
  output logic pinOut,
  output logic pinOe,
  output logic intrusionLatch
);
  logic out_r, out_nxt, oe_r, oe_nxt, latch_r, latch_nxt;
  logic dirOut, lvl, dflt, intrusionSub;

  assign dirOut = secondParameter[`ICG_P2_DIR_BIT];
  assign lvl = secondParameter[`ICG_P2_LEVEL_BIT];
  assign dflt = addrCfg[`ICG_CFG_DEFAULT_BIT];
  assign intrusionSub = addrCfg[`ICG_CFG_SUBMODE_BIT];

  always_comb begin
    out_nxt = out_r;
    oe_nxt = oe_r;
    latch_nxt = latch_r;
    err = 1'b0;
    stateByte = 8'h00;
    case (pinFn)
      ICG_PIN_DISABLED: begin
        err = 1'b1;
      end
      ICG_PIN_AUTH: begin
        if (intrusionSub) begin
          stateByte = {7'h0, latch_r};
          if (go && dirOut && authMatch) begin
            latch_nxt = lvl;
          end
        end else begin
          stateByte = {7'h0, out_r};
          if (go && dirOut) begin
            oe_nxt = 1'b1;
            if (lvl == dflt) begin
              out_nxt = dflt;
            end else if (authMatch) begin
              out_nxt = ~dflt;
            end
          end
        end
      end
      ICG_PIN_INPUT: begin
        stateByte = {7'h0, gpioIn};
        err = dirOut;
      end
      ICG_PIN_OUTPUT: begin
        stateByte = {7'h0, oe_r ? out_r : gpioIn};
        if (go) begin
          oe_nxt = dirOut;
          if (dirOut) begin
            out_nxt = lvl;
          end
        end
      end
      default: err = 1'b1;
    endcase
    if (!singleWire) begin
      err = 1'b1;
    end
    if (err) begin
      out_nxt = out_r;
      oe_nxt = oe_r;
      latch_nxt = latch_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      out_r <= 1'b0;
      oe_r <= 1'b0;
      latch_r <= 1'b0;
    end else begin
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      latch_r <= latch_nxt;
    end
  end

  assign pinOut = out_r;
  assign pinOe = oe_r;
  assign intrusionLatch = latch_r;
endmodule : icg_pin_ctrl

// ### hw/icg_wb_slave.sv
`timescale 1ns/1ps
`include "icg_consts.svh"
module icg_wb_slave import icg_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // wishbone
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [31:0] wbDatW,
  input wire logic [3:0] wbSel,
  output logic [31:0] wbDatR,
  output logic wbAck,
  // register side
  input wire logic [31:0] readMux,
  output logic wrStrobe,
  output logic [7:0] wrAddr,
  output logic [31:0] wrData,
  output logic [3:0] wrSel
);
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;

  always_comb begin
    ack_nxt = wbCyc & wbStb & ~ack_r;
    dat_nxt = dat_r;
    if (ack_nxt & ~wbWe) begin
      dat_nxt = readMux;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  // write acts in the ack cycle, so once per access
  assign wrStrobe = wbCyc & wbStb & wbWe & ack_r;
  assign wrAddr = wbAdr;
  assign wrData = wbDatW;
  assign wrSel = wbSel;
  assign wbAck = ack_r;
  assign wbDatR = dat_r;
endmodule : icg_wb_slave

// ### shared/icg_consts.svh
`ifndef ICG_CONSTS_SVH
`define ICG_CONSTS_SVH

// wishbone register map, byte addresses
`define ICG_ADDR_CMD 8'h00
`define ICG_ADDR_CFG 8'h04
`define ICG_ADDR_STATE 8'h08
`define ICG_ADDR_RESP 8'h0c
`define ICG_ADDR_STAT 8'h10
`define ICG_ADDR_PIN 8'h14

// command word fields
`define ICG_OPCODE_INFO 8'h30
`define ICG_CMD_OP_MSB 31
`define ICG_CMD_OP_LSB 24
`define ICG_CMD_MODE_MSB 23
`define ICG_CMD_MODE_LSB 16

// info modes
`define ICG_MODE_STATE 8'h02
`define ICG_MODE_PIN 8'h03

// address configuration byte bits
`define ICG_CFG_SUBMODE_BIT 3
`define ICG_CFG_DEFAULT_BIT 2

// second parameter bits
`define ICG_P2_DIR_BIT 1
`define ICG_P2_LEVEL_BIT 0

// error codes
`define ICG_ERR_PARSE 8'h03
`define ICG_ERR_EXEC 8'h0f

// timing: execution delay of one cycle at 250 MHz
`define ICG_EXEC_NS 4
`define ICG_CLK_NS 4
`define ICG_EXEC_CYC ((`ICG_EXEC_NS + `ICG_CLK_NS - 1) / `ICG_CLK_NS)

`endif

// ### shared/icg_pkg.sv
package icg_pkg;
  typedef enum logic [1:0] {
    ICG_PIN_DISABLED,
    ICG_PIN_AUTH,
    ICG_PIN_INPUT,
    ICG_PIN_OUTPUT
  } icg_pin_fn_t;

  typedef enum {
    ICG_IDLE,
    ICG_EXEC,
    ICG_DONE
  } icg_state_t;
endpackage : icg_pkg

// ### verif/icg_info_cmd_chk.sv
`timescale 1ns/1ps
`include "icg_consts.svh"
module icg_info_cmd_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // wishbone
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [31:0] wbDatR,
  input wire logic wbAck,
  // pin
  input wire logic gpioOut,
  input wire logic gpioOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ack_pulse_a: assert property (wbAck |=> !wbAck)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("request not answered next cycle");
  ack_cause_a: assert property (wbAck |-> $past(wbCyc && wbStb))
    else $error("ack without request");
  unmapped_zero_a: assert property (wbAck && $past(!wbWe && wbAdr == 8'h20) |-> wbDatR == 32'h0)
    else $error("unmapped read not zero");
  pin_read_a: assert property (wbAck && $past(!wbWe && wbAdr == `ICG_ADDR_PIN)
    |-> wbDatR[1:0] == {$past(gpioOe), $past(gpioOut)})
    else $error("pin readback differs from pin");
  pin_cause_a: assert property ($changed({gpioOe, gpioOut})
    |-> $past(wbWe && wbAck, 1) || $past(wbWe && wbAck, 2) || $past(wbWe && wbAck, 3))
    else $error("pin moved without a command");
  reset_pin_a: assert property (disable iff (1'b0) !rst_b |=> !gpioOe && !gpioOut)
    else $error("pin not idle after reset");
  reset_bus_a: assert property (disable iff (1'b0) !rst_b |=> !wbAck && wbDatR == 32'h0)
    else $error("bus not idle after reset");
endmodule : icg_info_cmd_chk

bind icg_info_cmd icg_info_cmd_chk icg_info_cmd_chk_i (.clk(clk), .rst_b(rst_b), .wbCyc(wbCyc),
  .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbDatR(wbDatR), .wbAck(wbAck),
  .gpioOut(gpioOut), .gpioOe(gpioOe));

// ### verif/icg_info_cmd_tb.sv
`timescale 1ns/1ps
`include "icg_consts.svh"
module icg_info_cmd_tb;
  import icg_pkg::*;
  logic clk = 0, rst_b = 0, wbCyc = 0, wbStb = 0, wbWe = 0;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDatW = 32'h0, wbDatR, q;
  logic [3:0] wbSel = 4'h0, authSlot = 4'h0;
  logic wbAck, authDone = 0, authClear = 0, volSeed = 0, nvSeed = 0;
  logic gpioIn, gpioOut, gpioOe, extLevel = 1;
  int fail_count = 0, check_count = 0;
  always #2 clk = ~clk;
  icg_info_cmd icg_info_cmd_i (.clk(clk), .rst_b(rst_b), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbDatW(wbDatW), .wbSel(wbSel), .wbDatR(wbDatR), .wbAck(wbAck),
    .authDone(authDone), .authSlot(authSlot), .authClear(authClear),
    .volatileSeedEvent(volSeed), .nonvolatileSeedEvent(nvSeed), .gpioIn(gpioIn),
    .gpioOut(gpioOut), .gpioOe(gpioOe));
  icg_pin_model icg_pin_model_i (.gpioOut(gpioOut), .gpioOe(gpioOe), .extLevel(extLevel),
    .gpioIn(gpioIn));
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, s, e);
    end
  endtask : check
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wbCyc <= 1;
    wbStb <= 1;
    wbWe <= we;
    wbAdr <= a;
    wbDatW <= d;
    wbSel <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    q = wbDatR;
    wbCyc <= 0;
    wbStb <= 0;
    wbWe <= 0;
    @(posedge clk);
  endtask : xfer
  task automatic cmd(input logic [31:0] w, input logic [7:0] err, input logic [31:0] rsp);
    int n;
    xfer(1, `ICG_ADDR_CMD, w);
    n = 0;
    do begin
      xfer(0, `ICG_ADDR_STAT, 32'h0);
      n++;
    end while (q[1] !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    check({24'h0, q[15:8]}, {24'h0, err});
    if (err == 8'h00) begin
      xfer(0, `ICG_ADDR_RESP, 32'h0);
      check(q, rsp);
    end
  endtask : cmd
  task automatic pulse(input int k, input logic [3:0] s);
    authSlot <= s;
    authDone <= (k == 0);
    authClear <= (k == 1);
    volSeed <= (k == 2);
    nvSeed <= (k == 3);
    @(posedge clk);
    {authDone, authClear, volSeed, nvSeed} <= 4'h0;
    @(posedge clk);
  endtask : pulse
  task automatic pinIs(input logic [2:0] m, input logic [2:0] e);
    xfer(0, `ICG_ADDR_PIN, 32'h0);
    check({29'h0, q[2:0] & m}, {29'h0, e});
    check({30'h0, gpioOe & m[1], gpioOut & m[0]}, {30'h0, e[1:0]});
  endtask : pinIs
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  // bits 15:2 of the second parameter always zero here
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    xfer(0, `ICG_ADDR_STATE, 32'h0);
    check(q, 32'h0);
    cmd(32'h30030000, `ICG_ERR_EXEC, 0);
    pulse(2, 4'h0);
    xfer(0, `ICG_ADDR_STATE, 32'h0);
    check(q, 32'h00000002);
    pulse(3, 4'h0);
    pulse(0, 4'h5);
    cmd(32'h30020000, 0, 32'h002f0000);
    cmd(32'h30000000, `ICG_ERR_PARSE, 0);
    cmd(32'h30010000, `ICG_ERR_PARSE, 0);
    cmd(32'h30040000, `ICG_ERR_PARSE, 0);
    cmd(32'h31020000, `ICG_ERR_PARSE, 0);
    $display("state and parse tests done");
    xfer(1, `ICG_ADDR_CFG, 32'h00000300);
    cmd(32'h30030003, `ICG_ERR_EXEC, 0);
    pinIs(3'h3, 0);
    xfer(1, `ICG_ADDR_CFG, 32'h00001200);
    cmd(32'h30030001, 0, 32'h01000000);
    extLevel <= 0;
    cmd(32'h30030001, 0, 32'h0);
    extLevel <= 1;
    pinIs(3'h2, 0);
    cmd(32'h30030002, `ICG_ERR_EXEC, 0);
    xfer(1, `ICG_ADDR_CFG, 32'h00001300);
    cmd(32'h30030003, 0, 32'h01000000);
    pinIs(3'h3, 3'h3);
    cmd(32'h30030002, 0, 32'h01000000);
    pinIs(3'h3, 3'h2);
    cmd(32'h30030001, 0, 32'h0);
    pinIs(3'h2, 0);
    $display("plain pin tests done");
    xfer(1, `ICG_ADDR_CFG, 32'h00051104);
    cmd(32'h30030002, 0, 32'h0);
    pinIs(3'h3, 3'h2);
    cmd(32'h30030003, 0, 32'h0);
    pinIs(3'h3, 3'h3);
    pulse(1, 4'h0);
    cmd(32'h30030002, 0, 32'h01000000);
    pinIs(3'h1, 3'h1);
    xfer(1, `ICG_ADDR_CFG, 32'h0005110c);
    cmd(32'h30030003, 0, 32'h0);
    pinIs(3'h4, 0);
    pulse(0, 4'h5);
    cmd(32'h30030003, 0, 32'h0);
    pulse(0, 4'h3);
    cmd(32'h30030002, 0, 32'h01000000);
    pinIs(3'h4, 3'h4);
    xfer(0, 8'h20, 32'h0);
    check(q, 32'h0);
    $display("authorization pin tests done");
    print_verdict();
  end
  initial begin
    #40000;
    fail_count++;
    print_verdict();
  end
endmodule : icg_info_cmd_tb

// ### verif/icg_pin_model.sv
`timescale 1ns/1ps
module icg_pin_model (
  // pin
  input wire logic gpioOut,
  input wire logic gpioOe,
  input wire logic extLevel,
  output logic gpioIn
);
  // external source wins only while the device releases the pin
  assign gpioIn = gpioOe ? gpioOut : extLevel;
endmodule : icg_pin_model
